// >>> hw/ic5_top.sv
// One 16-bit down-counter channel of an interval timer, all six modes.
// Assumes control and count writes arrive as one-cycle strobes on core_clk,
// and that the counter clock and trigger input are synchronous to core_clk.
//
// How it works
// - Hardware strobe mode output starts high; loading waits for a trigger edge.
// - On expiry in hardware strobe mode output goes low for one pulse.
// - Load waits for the pulse after a trigger; strobe comes N+1 pulses later.
// - Each trigger reloads the count on the next pulse, restarting the delay.
// - Trigger level never drives the output directly in hardware strobe mode.
// - A new count mid-sequence waits for a trigger before it is loaded.
// - The trigger input is sampled on every counter clock rising edge.
// - In modes 0, 2, 3, 4 the sampled trigger level gates counting.
// - In modes 2 and 3 a low trigger stops counting, forces output high.
// - In modes 1, 2, 3, 5 a rising trigger edge reloads the count.
// - A catch flop holds each trigger edge until the next sampling edge.
// - A control write resets the channel and sets the mode's initial output.
// - Loading and decrementing happen only on the counter clock falling edge.
// - Count zero acts as the largest count, 65536 binary or 10000 BCD.
// - Modes 0, 1, 4, 5 wrap past zero to FFFF or 9999.
// - Modes 2 and 3 reload the initial count at the end of each period.
// - A pulse is a counter clock rising edge then a falling edge.
// - Loading copies the preset holding register into the counting element, bit 0 cleared in mode 3.
`timescale 1ns/1ps
`default_nettype none

`include "ic5_params.svh"

module ic5_top (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  cw_wr,
  input  wire logic [2:0]            cw_mode,
  input  wire logic                  cw_bcd,
  input  wire logic                  cnt_wr,
  input  wire logic [`IC5_CNT_W-1:0] cnt_data,
  input  wire logic                  tmr_clk,
  input  wire logic                  trig_in,
  output logic                       tmr_out,
  output logic      [`IC5_CNT_W-1:0] count_val
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ic5_pkg::ic5_mode_e mode_r;
  ic5_pkg::ic5_mode_e mode_in;
  ic5_pkg::ic5_cnt_t  preset_holding_reg_r;
  ic5_pkg::ic5_cnt_t  cnt_r;
  ic5_pkg::ic5_cnt_t  cnt_nxt;
  ic5_pkg::ic5_cnt_t  dec_res;
  logic               bcd_r;
  logic               out_r;
  logic               out_nxt;
  logic               have_cnt_r;
  logic               load_pend_r;
  logic               load_pend_nxt;
  logic               armed_r;
  logic               armed_nxt;
  logic               odd_hold_r;
  logic               hold_nxt;

  ic5_ev_if ev ();

  ic5_edge u_edge (
    .core_clk (core_clk),
    .srst     (srst),
    .tmr_clk  (tmr_clk),
    .trig_in  (trig_in),
    .cw_wr    (cw_wr),
    .ev       (ev.src)
  );

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  // Codes 6 and 7 alias the periodic modes
  wire [2:0] mode_code = cw_mode[1] ? {1'b0, cw_mode[1:0]} : cw_mode;
  assign mode_in = ic5_pkg::ic5_mode_e'(mode_code);

  wire is_m5 = (mode_r == ic5_pkg::ic5_m_hwstb);
  wire mode23 = (mode_r == ic5_pkg::ic5_m_rate) || (mode_r == ic5_pkg::ic5_m_square);
  wire lvl_mode = (mode_r == ic5_pkg::ic5_m_intr) || (mode_r == ic5_pkg::ic5_m_swstb)
                  || mode23;
  wire edge_mode = (mode_r == ic5_pkg::ic5_m_oneshot) || is_m5 || mode23;
  wire sq_mode = (mode_r == ic5_pkg::ic5_m_square);
  // Software-loaded modes; periodic ones only take the first count this way
  wire sw_load = (mode_r == ic5_pkg::ic5_m_intr) || (mode_r == ic5_pkg::ic5_m_swstb)
                 || (mode23 && !have_cnt_r);

  // ---------------------------------------------------------------
  // Count control
  // ---------------------------------------------------------------
  wire cnt_en = lvl_mode ? ev.gate_lvl : 1'b1;
  wire trig_ld = edge_mode && ev.trig_hit && have_cnt_r;
  wire load_now = ev.tck_fall && (load_pend_r || trig_ld);
  wire dec_ok = ev.tck_fall && have_cnt_r && cnt_en && !load_now;
  wire dec_zero = (dec_res == `IC5_CNT_ZERO);
  wire odd_cnt = preset_holding_reg_r[0];
  // Odd square-wave counts load one less so the half steps stay even
  wire [`IC5_CNT_W-1:0] ld_val = sq_mode ? (preset_holding_reg_r & `IC5_EVEN_MASK)
                                         : preset_holding_reg_r;
  wire [3:0] step = sq_mode ? `IC5_STEP_TWO : `IC5_STEP_ONE;

  // Zero count needs no special case: the first step wraps to the top
  ic5_dec u_dec (
    .val  (cnt_r),
    .bcd  (bcd_r),
    .step (step),
    .res  (dec_res)
  );

  // ---------------------------------------------------------------
  // Next state per counter clock pulse
  // ---------------------------------------------------------------
  always_comb begin
    cnt_nxt       = cnt_r;
    out_nxt       = out_r;
    armed_nxt     = armed_r;
    hold_nxt      = odd_hold_r;
    load_pend_nxt = load_pend_r;
    if (load_now) begin
      load_pend_nxt = 1'b0;
    end
    if (ev.tck_fall) begin
      unique case (mode_r)
        ic5_pkg::ic5_m_intr: begin
          if (load_now) begin
            cnt_nxt = ld_val;
          end else if (dec_ok) begin
            cnt_nxt = dec_res;
            if (dec_zero) begin
              out_nxt = 1'b1;
            end
          end
        end
        ic5_pkg::ic5_m_oneshot: begin
          if (load_now) begin
            cnt_nxt   = ld_val;
            out_nxt   = 1'b0;
            armed_nxt = 1'b1;
          end else if (dec_ok) begin
            cnt_nxt = dec_res;
            if (dec_zero && armed_r) begin
              out_nxt   = 1'b1;
              armed_nxt = 1'b0;
            end
          end
        end
        ic5_pkg::ic5_m_rate: begin
          // A count of one would never leave the high phase
          if (load_now || (dec_ok && cnt_r == `IC5_CNT_ONE)) begin
            cnt_nxt = ld_val;
            out_nxt = 1'b1;
          end else if (dec_ok) begin
            cnt_nxt = dec_res;
            out_nxt = (dec_res != `IC5_CNT_ONE);
          end
        end
        ic5_pkg::ic5_m_square: begin
          if (load_now) begin
            cnt_nxt  = ld_val;
            out_nxt  = 1'b1;
            hold_nxt = 1'b0;
          end else if (dec_ok && cnt_r == `IC5_CNT_TWO) begin
            // Odd counts stretch the high half by one pulse
            if (odd_cnt && out_r && !odd_hold_r) begin
              hold_nxt = 1'b1;
            end else begin
              cnt_nxt  = ld_val;
              out_nxt  = ~out_r;
              hold_nxt = 1'b0;
            end
          end else if (dec_ok) begin
            cnt_nxt = dec_res;
          end
        end
        ic5_pkg::ic5_m_swstb,
        ic5_pkg::ic5_m_hwstb: begin
          if (!out_r) begin
            out_nxt = 1'b1;
          end
          if (load_now) begin
            cnt_nxt   = ld_val;
            armed_nxt = 1'b1;
          end else if (dec_ok) begin
            cnt_nxt = dec_res;
            if (dec_zero && armed_r) begin
              out_nxt   = 1'b0;
              armed_nxt = 1'b0;
            end
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
    // Gate low wins over any pulse in the periodic modes
    if (mode23 && !trig_in) begin
      out_nxt = 1'b1;
    end
    if (cnt_wr && sw_load) begin
      load_pend_nxt = 1'b1;
    end
    if (cnt_wr && mode_r == ic5_pkg::ic5_m_intr) begin
      out_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_r               <= ic5_pkg::ic5_m_intr;
      bcd_r                <= 1'b0;
      preset_holding_reg_r <= `IC5_CNT_ZERO;
      cnt_r                <= `IC5_CNT_ZERO;
      out_r                <= `IC5_OUT_RST;
      have_cnt_r           <= 1'b0;
      load_pend_r          <= 1'b0;
      armed_r              <= 1'b0;
      odd_hold_r           <= 1'b0;
    end else if (cw_wr) begin
      mode_r      <= mode_in;
      bcd_r       <= cw_bcd;
      out_r       <= (mode_in != ic5_pkg::ic5_m_intr);
      have_cnt_r  <= 1'b0;
      load_pend_r <= 1'b0;
      armed_r     <= 1'b0;
      odd_hold_r  <= 1'b0;
    end else begin
      // A write only fills the preset; the running count is untouched
      if (cnt_wr) begin
        preset_holding_reg_r <= cnt_data;
        have_cnt_r           <= 1'b1;
      end
      cnt_r       <= cnt_nxt;
      out_r       <= out_nxt;
      load_pend_r <= load_pend_nxt;
      armed_r     <= armed_nxt;
      odd_hold_r  <= hold_nxt;
    end
  end

  assign tmr_out   = out_r;
  assign count_val = cnt_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_cw_out_init: assert property (
    @(posedge core_clk) disable iff (srst)
    cw_wr |=> (out_r == (mode_r != ic5_pkg::ic5_m_intr)))
    else $error("control write did not set initial output");

  a_strobe_low_hold: assert property (
    @(posedge core_clk) disable iff (srst)
    is_m5 && !out_r && !ev.tck_fall && !cw_wr |=> !out_r)
    else $error("strobe ended before the pulse finished");

  a_strobe_one_pulse: assert property (
    @(posedge core_clk) disable iff (srst)
    is_m5 && !out_r && ev.tck_fall && !cw_wr |=> out_r)
    else $error("strobe lasted more than one pulse");

  a_load_after_trig: assert property (
    @(posedge core_clk) disable iff (srst)
    is_m5 && load_now |-> ev.trig_hit)
    else $error("hardware strobe loaded without a trigger");

  a_retrig_reload: assert property (
    @(posedge core_clk) disable iff (srst)
    is_m5 && ev.tck_fall && ev.trig_hit && have_cnt_r && !cw_wr
    |=> cnt_r == $past(preset_holding_reg_r))
    else $error("trigger did not reload the preset");

  a_gate_no_out: assert property (
    @(posedge core_clk) disable iff (srst)
    is_m5 && !ev.tck_fall && !cw_wr |=> $stable(out_r))
    else $error("output moved between counter clock pulses");

  a_trig_caught: assert property (
    @(posedge core_clk) disable iff (srst)
    $rose(trig_in) && !cw_wr |=> ev.trig_cap || ev.trig_hit)
    else $error("trigger edge was not caught");

  a_fall_only: assert property (
    @(posedge core_clk) disable iff (srst)
    !ev.tck_fall |=> $stable(cnt_r))
    else $error("count changed off the falling edge");

  a_gate_forces_high: assert property (
    @(posedge core_clk) disable iff (srst)
    mode23 && !trig_in && !cw_wr |=> out_r)
    else $error("low gate did not force output high");

  a_gate_level_hold: assert property (
    @(posedge core_clk) disable iff (srst)
    lvl_mode && ev.tck_fall && !ev.gate_lvl && !load_now && !cw_wr
    |=> $stable(cnt_r))
    else $error("counted while gate level was low");

  a_wrap_top: assert property (
    @(posedge core_clk) disable iff (srst)
    is_m5 && dec_ok && cnt_r == `IC5_CNT_ZERO && !cw_wr
    |=> cnt_r == (bcd_r ? `IC5_BCD_TOP : `IC5_BIN_TOP))
    else $error("count did not wrap to the top value");

  a_rate_reload: assert property (
    @(posedge core_clk) disable iff (srst)
    mode_r == ic5_pkg::ic5_m_rate && dec_ok && cnt_r == `IC5_CNT_ONE && !cw_wr
    |=> cnt_r == $past(preset_holding_reg_r))
    else $error("rate mode did not reload at period end");

endmodule : ic5_top

`default_nettype wire

// >>> include/ic5_params.svh
// Constants for the interval counter channel: count limits, steps, reset levels.
// Assumes a 16-bit counting element and a four-digit BCD option.
`ifndef IC5_PARAMS_SVH
`define IC5_PARAMS_SVH

`define IC5_CNT_W      16
`define IC5_CNT_ZERO   16'h0000
`define IC5_CNT_ONE    16'h0001
`define IC5_CNT_TWO    16'h0002
`define IC5_BIN_TOP    16'hFFFF
`define IC5_BCD_TOP    16'h9999
`define IC5_EVEN_MASK  16'hFFFE
`define IC5_STEP_ONE   4'h1
`define IC5_STEP_TWO   4'h2
`define IC5_BCD_TEN    4'hA
`define IC5_OUT_RST    1'b1

`endif

// >>> include/ic5_pkg.sv
// Types shared by the interval counter channel modules.
// Assumes ic5_params.svh is on the include path.
`include "ic5_params.svh"

package ic5_pkg;

  // ---------------------------------------------------------------
  // Counter modes, in programming order
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ic5_m_intr,
    ic5_m_oneshot,
    ic5_m_rate,
    ic5_m_square,
    ic5_m_swstb,
    ic5_m_hwstb
  } ic5_mode_e;

  typedef logic [`IC5_CNT_W-1:0] ic5_cnt_t;

endpackage : ic5_pkg

// >>> include/ic5_ev_if.sv
// Event bundle from the edge sampler to the counter core.
// Assumes all members are driven in the core_clk domain.
`timescale 1ns/1ps
`default_nettype none

interface ic5_ev_if;
  logic tck_rise;
  logic tck_fall;
  logic trig_cap;
  logic trig_hit;
  logic gate_lvl;
  modport src (output tck_rise, tck_fall, trig_cap, trig_hit, gate_lvl);
  modport snk (input tck_rise, tck_fall, trig_cap, trig_hit, gate_lvl);
endinterface : ic5_ev_if

`default_nettype wire

// >>> hw/ic5_edge.sv
// Samples the counter clock and trigger input, and holds the trigger catch flop.
// Assumes tmr_clk and trig_in are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module ic5_edge (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic tmr_clk,
  input  wire logic trig_in,
  input  wire logic cw_wr,
  ic5_ev_if.src     ev
);

  logic tck_d_r;
  logic trig_d_r;
  logic trig_cap_r;
  logic trig_hit_r;
  logic gate_lvl_r;

  wire trig_rise = trig_in & ~trig_d_r;

  // ---------------------------------------------------------------
  // Counter clock pulse edges
  // ---------------------------------------------------------------
  assign ev.tck_rise = tmr_clk & ~tck_d_r;
  assign ev.tck_fall = ~tmr_clk & tck_d_r;
  assign ev.trig_cap = trig_cap_r;
  assign ev.trig_hit = trig_hit_r;
  assign ev.gate_lvl = gate_lvl_r;

  always_ff @(posedge core_clk) begin
    if (srst || cw_wr) begin
      tck_d_r    <= tmr_clk & ~srst;
      trig_d_r   <= trig_in & ~srst;
      trig_cap_r <= 1'b0;
      trig_hit_r <= 1'b0;
      gate_lvl_r <= 1'b0;
    end else begin
      tck_d_r  <= tmr_clk;
      trig_d_r <= trig_in;
      // Edge arriving with the sampling edge goes straight to the hit flop
      if (trig_rise && !ev.tck_rise) begin
        trig_cap_r <= 1'b1;
      end else if (ev.tck_rise) begin
        trig_cap_r <= 1'b0;
      end
      if (ev.tck_rise) begin
        trig_hit_r <= trig_cap_r | trig_rise;
        gate_lvl_r <= trig_in;
      end else if (ev.tck_fall) begin
        trig_hit_r <= 1'b0;
      end
    end
  end

endmodule : ic5_edge

`default_nettype wire

// >>> hw/ic5_dec.sv
// Down-step of the counting element in binary or four-digit BCD.
// Assumes step is one or two; wraps below zero to the top count.
`timescale 1ns/1ps
`default_nettype none

`include "ic5_params.svh"

module ic5_dec (
  input  wire logic [`IC5_CNT_W-1:0] val,
  input  wire logic                  bcd,
  input  wire logic [3:0]            step,
  output logic      [`IC5_CNT_W-1:0] res
);

  localparam int DIGITS = `IC5_CNT_W / 4;

  function automatic logic [4:0] ic5_bcd_sub(input logic [3:0] d, input logic [3:0] s);
    logic [4:0] t;
    t = {1'b0, d} - {1'b0, s};
    ic5_bcd_sub = t[4] ? {1'b1, 4'(t[3:0] + `IC5_BCD_TEN)} : {1'b0, t[3:0]};
  endfunction : ic5_bcd_sub

  logic [`IC5_CNT_W-1:0] bcd_res;
  logic [3:0]            sub_v;
  logic [4:0]            dig;

  always_comb begin
    bcd_res = '0;
    sub_v   = step;
    dig     = '0;
    for (int i = 0; i < DIGITS; i++) begin
      dig                = ic5_bcd_sub(val[i*4 +: 4], sub_v);
      bcd_res[i*4 +: 4]  = dig[3:0];
      sub_v              = {3'h0, dig[4]};
    end
  end

  // Borrow out of the top digit is dropped so zero wraps to the top count
  assign res = bcd ? bcd_res : val - `IC5_CNT_W'(step);

endmodule : ic5_dec

`default_nettype wire

// >>> tb/ic5_host.sv
// Host model for the interval counter channel: setup and count writes.
// Assumes the bench calls its tasks; every drive lands on a core_clk rise.
`timescale 1ns/1ps
`default_nettype none

module ic5_host (
  input  wire logic           core_clk,
  output var  logic           cw_wr,
  output var  logic [2:0]     cw_mode,
  output var  logic           cw_bcd,
  output var  logic           cnt_wr,
  output var  ic5_pkg::ic5_cnt_t cnt_data
);
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  initial begin
    cw_wr = 1'b0;
    cw_mode = 3'h0;
    cw_bcd = 1'b0;
    cnt_wr = 1'b0;
    cnt_data = 16'h0000;
  end

  // ---------------------------------------------------------------
  // Write cycles
  // ---------------------------------------------------------------
  // Released lines flip so a stale value never looks valid
  task automatic write_ctrl(input logic [2:0] md, input logic bcd);
    @(posedge core_clk);
    cw_wr <= 1'b1;
    cw_mode <= md;
    cw_bcd <= bcd;
    @(posedge core_clk);
    cw_wr <= 1'b0;
    cw_mode <= ~md;
    cw_bcd <= ~bcd;
    @(posedge core_clk);
  endtask : write_ctrl

  // Callers send only legal counts: 0 (largest count) or 1 up, 2 up in modes 2 and 3
  task automatic write_count(input ic5_pkg::ic5_cnt_t v);
    @(posedge core_clk);
    cnt_wr <= 1'b1;
    cnt_data <= v;
    @(posedge core_clk);
    cnt_wr <= 1'b0;
    cnt_data <= ~v;
  endtask : write_count
endmodule : ic5_host

`default_nettype wire

// >>> tb/test_interval_counter_gate_mode5.sv
// Self-checking bench: integer model of the channel, compared after every pulse.
// Assumes ic5_top, ic5_host and ic5_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_interval_counter_gate_mode5;
  logic              core_clk = 1'b0;
  logic              srst     = 1'b1;
  logic              tmr_clk  = 1'b0;
  logic              trig_in  = 1'b0;
  logic              cw_wr;
  logic              cw_bcd;
  logic              cnt_wr;
  logic [2:0]        cw_mode;
  ic5_pkg::ic5_cnt_t cnt_data;
  ic5_pkg::ic5_cnt_t count_val;
  logic              tmr_out;
  int                error_cnt = 0;
  int                compares  = 0;
  integer            seed      = 32'hFE7CAFCA;
  int m_mode, m_bcd, m_pre, m_ce, m_out, m_have, m_live, m_arm, m_ldq, m_pend, n;

  always #5 core_clk = ~core_clk;

  ic5_host ic5_host_i (.core_clk(core_clk), .cw_wr(cw_wr), .cw_mode(cw_mode),
    .cw_bcd(cw_bcd), .cnt_wr(cnt_wr), .cnt_data(cnt_data));

  ic5_top ic5_top_i (.core_clk(core_clk), .srst(srst), .cw_wr(cw_wr), .cw_mode(cw_mode),
    .cw_bcd(cw_bcd), .cnt_wr(cnt_wr), .cnt_data(cnt_data), .tmr_clk(tmr_clk),
    .trig_in(trig_in), .tmr_out(tmr_out), .count_val(count_val));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input ic5_pkg::ic5_cnt_t seen, input ic5_pkg::ic5_cnt_t exp,
                     input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  function automatic ic5_pkg::ic5_cnt_t enc(input int v);
    if (m_bcd != 0)
      return {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10), 4'(v % 10)};
    return 16'(v);
  endfunction : enc

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic setup(input int md, input int bcd);
    ic5_host_i.write_ctrl(3'(md), bcd[0]);
    // Codes 6 and 7 alias the periodic modes
    m_mode = (md > 5) ? md - 4 : md;
    m_bcd = bcd;
    m_out = (md == 0) ? 0 : 1;
    m_have = 0;
    m_live = 0;
    m_arm = 0;
    m_ldq = 0;
    m_pend = 0;
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0, tmr_out}, 16'(m_out), "setup out");
  endtask : setup

  task automatic load(input int v);
    ic5_host_i.write_count(enc(v));
    m_pre = v;
    m_have = 1;
    if (m_mode == 0 || m_mode == 4 || (m_mode >= 2 && m_mode <= 3 && m_live == 0)) m_ldq = 1;
    if (m_mode == 0) m_out = 0;
  endtask : load

  task automatic set_gate(input logic v);
    @(posedge core_clk);
    if (v && !trig_in) m_pend = 1;
    if (!v && (m_mode == 2 || m_mode == 3)) m_out = 1;
    trig_in <= v;
  endtask : set_gate

  task automatic trig();
    set_gate(1'b1);
    set_gate(1'b0);
  endtask : trig

  // One counter pulse: rise, hold, fall, then compare with the model
  task automatic pulse();
    int g;
    int hit;
    @(posedge core_clk);
    tmr_clk <= 1'b1;
    g = trig_in;
    hit = m_pend;
    m_pend = 0;
    repeat (4) @(posedge core_clk);
    #1;
    if (m_live != 0) chk(count_val, enc(m_ce), "count moved on rise");
    @(posedge core_clk);
    tmr_clk <= 1'b0;
    if (hit != 0 && m_have != 0 && (m_mode % 4) != 0) m_ldq = 1;
    if (m_mode == 2 && m_live != 0 && g != 0 && m_out == 0) m_ldq = 1;
    // Strobe modes: low lasts one pulse, whatever the gate does
    if (m_mode >= 4) m_out = 1;
    if (m_ldq != 0) begin
      m_ce = m_pre;
      m_live = 1;
      m_arm = 1;
      m_ldq = 0;
      m_out = (m_mode <= 1) ? 0 : 1;
    end else if (m_live != 0 && (g != 0 || m_mode == 1 || m_mode == 5)) begin
      if (m_mode == 3 && m_ce == 2) begin
        m_ce = m_pre;
        m_out = 1 - m_out;
      end else begin
        m_ce = (m_ce == 0) ? ((m_bcd != 0) ? 9999 : 65535) : m_ce - ((m_mode == 3) ? 2 : 1);
        if (m_ce == ((m_mode == 2) ? 1 : 0) && m_arm != 0) begin
          m_out = (m_mode <= 1) ? 1 : 0;
          m_arm = (m_mode == 2) ? 1 : 0;
        end
      end
    end
    repeat (4) @(posedge core_clk);
    #1;
    if (m_live != 0) chk(count_val, enc(m_ce), "count");
    chk({15'h0, tmr_out}, 16'(m_out), "out");
  endtask : pulse

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({15'h0, tmr_out}, 16'h0001, "reset out");
    setup(0, 0);
    // Terminal count: write drops output, high at zero, then wraps
    set_gate(1'b1);
    load(3);
    repeat (5) pulse();
    set_gate(1'b0);
    // Hardware strobe: idle until trigger, strobe, retrigger, gate held high
    setup(5, 0);
    n = 1 + ({$random(seed)} % 4);
    load(n);
    repeat (2) pulse();
    trig();
    repeat (n + 3) pulse();
    trig();
    repeat (2) pulse();
    trig();
    repeat (n + 2) pulse();
    set_gate(1'b1);
    repeat (n + 3) pulse();
    set_gate(1'b0);
    // New count mid-sequence waits for the next trigger
    trig();
    pulse();
    load(n + 2);
    repeat (2) pulse();
    trig();
    repeat (n + 4) pulse();
    // Largest count, binary then BCD wrap
    setup(5, 0);
    load(0);
    trig();
    repeat (3) pulse();
    setup(5, 1);
    load(2);
    trig();
    repeat (5) pulse();
    // Software strobe with level gating
    setup(4, 0);
    set_gate(1'b1);
    n = 1 + ({$random(seed)} % 4);
    load(n);
    repeat (2) pulse();
    set_gate(1'b0);
    repeat (2) pulse();
    set_gate(1'b1);
    repeat (n + 2) pulse();
    // One-shot: trigger drops output until zero, retrigger restarts
    setup(1, 0);
    set_gate(1'b0);
    load(n);
    trig();
    repeat (2) pulse();
    trig();
    repeat (n + 2) pulse();
    // Square wave through the aliased code, even counts only
    setup(7, 0);
    set_gate(1'b1);
    load(2 * (1 + ({$random(seed)} % 3)));
    repeat (8) pulse();
    // Rate mode: periodic reload, gate low forces output high
    setup(2, 0);
    set_gate(1'b0);
    load(2 + ({$random(seed)} % 3));
    set_gate(1'b1);
    repeat (6) pulse();
    for (int i = 0; i < 6 && m_out != 0; i++) pulse();
    set_gate(1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0, tmr_out}, 16'h0001, "gate low out");
    repeat (2) pulse();
    set_gate(1'b1);
    repeat (6) pulse();
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end
endmodule : test_interval_counter_gate_mode5

`default_nettype wire
